//--- verilog/measure_timer_pkg.sv
// constants shared by the measuring timer block: offsets, fields, encodings
// assumes a byte-wide register port with 8-bit addresses
package measure_timer_pkg;

	// ----------------------------------------
	// bus geometry
	// ----------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFS_WIDE_MODE = 8'h28;
	localparam logic [7:0] OFS_SMALL_MODE = 8'h29;
	localparam logic [7:0] OFS_WIDE_LO = 8'h2A;
	localparam logic [7:0] OFS_WIDE_HI = 8'h2B;
	localparam logic [7:0] OFS_SMALL1 = 8'h2C;
	localparam logic [7:0] OFS_SMALL2 = 8'h2D;
	localparam logic [7:0] OFS_STATUS = 8'h2E;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] WIDE_MODE_RST = 8'h00;
	localparam logic [7:0] SMALL_MODE_RST = 8'h00;
	localparam logic [15:0] WIDE_CNT_RST = 16'hFFFF;
	localparam logic [7:0] SMALL_CNT_RST = 8'hFF;

	// ----------------------------------------
	// wide timer mode register fields
	// ----------------------------------------
	localparam int WM_STOP = 7;
	localparam int WM_POL = 6;
	localparam int WM_MODE_HI = 5;
	localparam int WM_MODE_LO = 4;
	localparam int WM_PRE_HI = 3;
	localparam int WM_PRE_LO = 2;
	localparam int WM_TOGGLE = 1;
	localparam int WM_LATCH_ONLY = 0;

	// ----------------------------------------
	// small timers mode register fields
	// ----------------------------------------
	localparam int SM_SRC_SEL = 0;
	localparam int SM_STOP1 = 1;
	localparam int SM_CLK1 = 2;
	localparam int SM_CLK2 = 3;
	localparam int SM_CLK3 = 4;
	localparam int SM_POL = 5;
	localparam int SM_EN = 6;
	localparam int SM_LATCH_ONLY = 7;

	// ----------------------------------------
	// status bits (write one to clear)
	// ----------------------------------------
	localparam int ST_WIDE_UF = 0;
	localparam int ST_PIN_EDGE = 1;
	localparam int ST_SMALL1_UF = 2;
	localparam int ST_SMALL2_UF = 3;

	// ----------------------------------------
	// wide timer modes and prescaler width
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_INTERVAL = 2'h0,
		MODE_PERIOD = 2'h1,
		MODE_EVENT = 2'h2,
		MODE_HL_WIDTH = 2'h3
	} wide_mode_t;
	localparam int PRESC_W = 6;

endpackage

//--- verilog/pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic pin,
	output logic level,
	output logic rise,
	output logic fall
);
	logic s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
	logic lvl_d, rise_d, fall_d;
	logic [1:0] arm_q, arm_d;

	// level changes only once stages two and three agree
	// while the chain fills the level is taken silently: no false edge after reset
	always_comb begin
		arm_d = (arm_q == 2'h3) ? arm_q : arm_q + 2'h1;
		if (arm_q != 2'h3) begin
			lvl_d = s2_q;
		end else begin
			lvl_d = (s2_q == s3_q) ? s3_q : lvl_q;
		end
		rise_d = lvl_d & ~lvl_q & (arm_q == 2'h3);
		fall_d = ~lvl_d & lvl_q & (arm_q == 2'h3);
	end

	// synchroniser chain and filtered level
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			arm_q <= 2'h0;
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			lvl_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			arm_q <= arm_d;
			s1_q <= pin;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
			rise_q <= rise_d;
			fall_q <= fall_d;
		end
	end

	assign level = lvl_q;
	assign rise = rise_q;
	assign fall = fall_q;
endmodule
`default_nettype wire

//--- verilog/small_timer.sv
// down counter with reload latch and underflow pulse
// assumes tick and write are one-cycle pulses on ref_clk
`timescale 1ns/1ps
`default_nettype none
module small_timer #(
	parameter int W = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic tick,
	input wire logic stop,
	input wire logic wr,
	input wire logic latch_only,
	input wire logic [W-1:0] wr_data,
	output logic [W-1:0] count,
	output logic underflow
);
	logic [W-1:0] cnt_q, cnt_d, lat_q, lat_d;
	logic uf_q, uf_d;

	// write, count down, reload on underflow
	always_comb begin
		lat_d = wr ? wr_data : lat_q;
		uf_d = tick & ~stop & (cnt_q == '0);
		cnt_d = cnt_q;
		if (wr && !latch_only) begin
			cnt_d = wr_data;
		end else if (uf_d) begin
			cnt_d = lat_q;
		end else if (tick && !stop) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	// state registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			cnt_q <= '1;
			lat_q <= '1;
			uf_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			lat_q <= lat_d;
			uf_q <= uf_d;
		end
	end

	assign count = cnt_q;
	assign underflow = uf_q;
endmodule
`default_nettype wire

//--- verilog/measure_timer.sv
// 16-bit measuring timer with two 8-bit timers and pulse output
// assumes a byte register port on ref_clk; pins are asynchronous
// Function
// - stop bit freezes wide count in all modes
// - interval mode: prescaled count, underflow flags, reloads
// - toggle control gates toggle onto event pin
// - underflow inverts pin output and flags request
// - polarity sets toggle start level, zero high
// - period mode, polarity zero: falling edge captures
// - period mode, polarity one: rising edge captures
// - measurement modes read back the capture value
// - measurement underflow still flags and reloads
// - event mode counts pin edges chosen by polarity
// - high/low mode captures on both edges
// - eight-bit timer with latch and pulse output
// - latch-only write defers counter load to underflow
// - reset clears shared write control bit
// - pulse polarity sets start level, one low
// - pulse enable bit drives pulse pin
// - mode bit zero picks toggling small timer
// - mode bits select wide timer mode
// - high read snapshots low byte for low read
// - low write held, high write loads both
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module measure_timer
	import measure_timer_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [DATA_W-1:0] rd_data,
	input wire logic wide_event_pin_i,
	output logic wide_event_pin_o,
	output logic wide_event_pin_oe,
	input wire logic sub_clock_input,
	output logic small_pulse_out,
	output logic small_pulse_out_oe
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [7:0] wmode_q, wmode_d, smode_q, smode_d, temp_lo_q, temp_lo_d;
	logic [7:0] snap_lo_q, snap_lo_d, rd_q, rd_d;
	logic [15:0] cnt_q, cnt_d, lat_q, lat_d, cap_q, cap_d, view;
	logic [3:0] st_q, st_d, st_set;
	logic [PRESC_W-1:0] presc_q, presc_d;
	logic tog_q, tog_d, oe_q, oe_d, pout_q, pout_d, poe_q, poe_d, half_q, half_d;
	logic ev_rise, ev_fall, sub_rise;
	logic wmode_wr, smode_wr, lo_wr, hi_wr, hi_rd, s1_wr, s2_wr;
	logic presc_tick, tick, cap, uf, meas, stop;
	logic t1_tick, t2_tick, t1_uf, t2_uf;
	logic [7:0] t1_cnt, t2_cnt;
	wide_mode_t mode;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	pin_sync u_ev_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin(wide_event_pin_i),
		.level(),
		.rise(ev_rise),
		.fall(ev_fall)
	);

	pin_sync u_sub_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.pin(sub_clock_input),
		.level(),
		.rise(sub_rise),
		.fall()
	);

	// ----------------------------------------
	// decode and wide timer controls
	// ----------------------------------------
	assign wmode_wr = wr_en && (addr == OFS_WIDE_MODE);
	assign smode_wr = wr_en && (addr == OFS_SMALL_MODE);
	assign lo_wr = wr_en && (addr == OFS_WIDE_LO);
	assign hi_wr = wr_en && (addr == OFS_WIDE_HI);
	assign s1_wr = wr_en && (addr == OFS_SMALL1);
	assign s2_wr = wr_en && (addr == OFS_SMALL2);
	assign hi_rd = rd_en && (addr == OFS_WIDE_HI);
	assign mode = wide_mode_t'(wmode_q[WM_MODE_HI:WM_MODE_LO]);
	assign stop = wmode_q[WM_STOP];
	assign meas = (mode == MODE_PERIOD) || (mode == MODE_HL_WIDTH);

	// prescaler tick: system clock by 8, 16, 32 or 64
	always_comb begin
		case (wmode_q[WM_PRE_HI:WM_PRE_LO])
			2'h0: presc_tick = &presc_q[2:0];
			2'h1: presc_tick = &presc_q[3:0];
			2'h2: presc_tick = &presc_q[4:0];
			default: presc_tick = &presc_q;
		endcase
	end

	// count source, capture edge and underflow
	always_comb begin
		case (mode)
			MODE_EVENT: tick = wmode_q[WM_POL] ? ev_fall : ev_rise;
			default: tick = presc_tick;
		endcase
		case (mode)
			MODE_PERIOD: cap = wmode_q[WM_POL] ? ev_rise : ev_fall;
			MODE_HL_WIDTH: cap = ev_rise | ev_fall;
			default: cap = 1'b0;
		endcase
		uf = tick && !stop && !cap && (cnt_q == 16'h0000);
		view = meas ? cap_q : cnt_q;
	end

	// ----------------------------------------
	// wide timer next state
	// ----------------------------------------
	always_comb begin
		presc_d = presc_q + 1'b1;
		wmode_d = wmode_wr ? wr_data : wmode_q;
		temp_lo_d = lo_wr ? wr_data : temp_lo_q;
		lat_d = hi_wr ? {wr_data, temp_lo_q} : lat_q;
		cap_d = cap ? cnt_q : cap_q;
		cnt_d = cnt_q;
		if (hi_wr && !wmode_q[WM_LATCH_ONLY]) begin
			cnt_d = {wr_data, temp_lo_q};
		end else if (stop) begin
			cnt_d = cnt_q;
		end else if (cap || uf) begin
			cnt_d = lat_q;
		end else if (tick) begin
			cnt_d = cnt_q - 1'b1;
		end
		// start level on mode write, invert on interval underflow
		if (wmode_wr) begin
			tog_d = ~wr_data[WM_POL];
		end else if (uf && mode == MODE_INTERVAL) begin
			tog_d = ~tog_q;
		end else begin
			tog_d = tog_q;
		end
		oe_d = (wmode_d[WM_MODE_HI:WM_MODE_LO] == MODE_INTERVAL) && wmode_d[WM_TOGGLE];
	end

	// wide timer registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			presc_q <= '0;
			wmode_q <= WIDE_MODE_RST;
			temp_lo_q <= 8'h00;
			lat_q <= WIDE_CNT_RST;
			cnt_q <= WIDE_CNT_RST;
			cap_q <= 16'h0000;
			tog_q <= 1'b1;
			oe_q <= 1'b0;
		end else begin
			presc_q <= presc_d;
			wmode_q <= wmode_d;
			temp_lo_q <= temp_lo_d;
			lat_q <= lat_d;
			cnt_q <= cnt_d;
			cap_q <= cap_d;
			tog_q <= tog_d;
			oe_q <= oe_d;
		end
	end

	// ----------------------------------------
	// small timers
	// ----------------------------------------
	// clock picks: first by 8 or sub clock by 2, second from first or system
	always_comb begin
		half_d = sub_rise ? ~half_q : half_q;
		t1_tick = smode_q[SM_CLK1] ? (sub_rise && half_q) : &presc_q[2:0];
		t2_tick = smode_q[SM_CLK2] ? 1'b1 : t1_uf;
	end

	small_timer #(.W(8)) u_small1 (
		.ref_clk(ref_clk),
		.reset(reset),
		.tick(t1_tick),
		.stop(smode_q[SM_STOP1]),
		.wr(s1_wr),
		.latch_only(smode_q[SM_LATCH_ONLY]),
		.wr_data(wr_data),
		.count(t1_cnt),
		.underflow(t1_uf)
	);

	small_timer #(.W(8)) u_small2 (
		.ref_clk(ref_clk),
		.reset(reset),
		.tick(t2_tick),
		.stop(1'b0),
		.wr(s2_wr),
		.latch_only(smode_q[SM_LATCH_ONLY]),
		.wr_data(wr_data),
		.count(t2_cnt),
		.underflow(t2_uf)
	);

	// pulse output level and enable
	always_comb begin
		smode_d = smode_wr ? wr_data : smode_q;
		if (smode_wr) begin
			pout_d = ~wr_data[SM_POL];
		end else if (smode_q[SM_SRC_SEL] ? t2_uf : t1_uf) begin
			pout_d = ~pout_q;
		end else begin
			pout_d = pout_q;
		end
		poe_d = smode_d[SM_EN];
	end

	// ----------------------------------------
	// status and register read
	// ----------------------------------------
	always_comb begin
		st_set = 4'h0;
		st_set[ST_WIDE_UF] = uf;
		st_set[ST_PIN_EDGE] = cap;
		st_set[ST_SMALL1_UF] = t1_uf;
		st_set[ST_SMALL2_UF] = t2_uf;
		// set wins over a write-one clear in the same cycle
		st_d = st_q & ~((wr_en && addr == OFS_STATUS) ? wr_data[3:0] : 4'h0) | st_set;
		snap_lo_d = hi_rd ? view[7:0] : snap_lo_q;
		rd_d = 8'h00;
		if (rd_en) begin
			case (addr)
				OFS_WIDE_MODE: rd_d = wmode_q;
				OFS_SMALL_MODE: rd_d = smode_q;
				OFS_WIDE_LO: rd_d = snap_lo_q;
				OFS_WIDE_HI: rd_d = view[15:8];
				OFS_SMALL1: rd_d = t1_cnt;
				OFS_SMALL2: rd_d = t2_cnt;
				OFS_STATUS: rd_d = {4'h0, st_q};
				default: rd_d = 8'h00;
			endcase
		end
	end

	// shared registers
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			smode_q <= SMALL_MODE_RST;
			pout_q <= 1'b1;
			poe_q <= 1'b0;
			half_q <= 1'b0;
			st_q <= 4'h0;
			snap_lo_q <= 8'h00;
			rd_q <= 8'h00;
		end else begin
			smode_q <= smode_d;
			pout_q <= pout_d;
			poe_q <= poe_d;
			half_q <= half_d;
			st_q <= st_d;
			snap_lo_q <= snap_lo_d;
			rd_q <= rd_d;
		end
	end

	assign rd_data = rd_q;
	assign wide_event_pin_o = tog_q;
	assign wide_event_pin_oe = oe_q;
	assign small_pulse_out = pout_q;
	assign small_pulse_out_oe = poe_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	AST_STOP_HOLD: assert property (stop && !hi_wr && !wmode_wr |=> $stable(cnt_q))
		else $error("count moved while stopped");
	AST_UF_RELOAD: assert property (uf && !hi_wr |=> cnt_q == $past(lat_q) && st_q[ST_WIDE_UF])
		else $error("underflow did not reload and flag");
	AST_TOGGLE: assert property (uf && mode == MODE_INTERVAL && !wmode_wr |=> tog_q != $past(tog_q))
		else $error("toggle output did not invert");
	AST_PIN_OE: assert property (wmode_wr && wr_data[WM_MODE_HI:WM_MODE_LO] != 2'h0 |=> !wide_event_pin_oe)
		else $error("event pin driven outside interval mode");
	AST_START_LEVEL: assert property (wmode_wr |=> wide_event_pin_o == !$past(wr_data[WM_POL]))
		else $error("wrong toggle start level");
	AST_CAPTURE: assert property (cap |=> cap_q == $past(cnt_q) && st_q[ST_PIN_EDGE])
		else $error("edge did not capture count");
	AST_READ_VIEW: assert property (hi_rd && meas |=> rd_data == $past(cap_q[15:8]))
		else $error("read did not return capture value");
	AST_EVENT_DEC: assert property (mode == MODE_EVENT && tick && !stop && cnt_q != 16'h0 && !hi_wr
		|=> cnt_q == $past(cnt_q) - 16'h1)
		else $error("event edge did not decrement");
	AST_WIDE_WR: assert property (lo_wr ##1 (hi_wr && !wmode_q[WM_LATCH_ONLY])
		|=> cnt_q == {$past(wr_data), $past(wr_data, 2)} && lat_q == cnt_q)
		else $error("wide write did not load both bytes");
	AST_SNAPSHOT: assert property (hi_rd ##1 (rd_en && addr == OFS_WIDE_LO) |=> rd_data == $past(view[7:0], 2))
		else $error("low read did not return snapshot");
	AST_SMALL_WR: assert property (s1_wr && !smode_q[SM_LATCH_ONLY] |=> t1_cnt == $past(wr_data))
		else $error("small timer write not loaded");
	AST_PULSE_EN: assert property (smode_wr |=> small_pulse_out_oe == $past(wr_data[SM_EN]))
		else $error("pulse enable not applied");

	COV_CAPTURE: cover property (cap ##1 hi_rd);
	COV_TOGGLE: cover property (uf && oe_q);
	COV_EVENT_UF: cover property (mode == MODE_EVENT && uf);
	COV_PULSE: cover property (poe_q && t1_uf);
endmodule
`default_nettype wire

//--- test/event_source.sv
// event waveform source for the shared event pin, plus the free sub clock
// assumes the bench sets the wanted level; the design may drive the wire itself
`timescale 1ns/1ps
`default_nettype none
module event_source (
	input wire logic ref_clk,
	input wire logic want_level,
	input wire logic [3:0] lag,
	input wire logic drv_o,
	input wire logic drv_oe,
	output logic pin,
	output logic sub_clk
);
	logic src_q = 1'b1;
	int wait_n = 0;
	// follow the wanted level after a lag, off the clock edge
	always @(posedge ref_clk) begin
		if (want_level === src_q) begin
			wait_n <= 0;
		end else if (wait_n >= lag) begin
			src_q <= #3 want_level;
			wait_n <= 0;
		end else begin
			wait_n <= wait_n + 1;
		end
	end
	// wire level: the device wins while it drives the pin
	assign pin = drv_oe ? drv_o : src_q;
	// sub clock crystal, unrelated in phase to ref_clk
	initial begin
		sub_clk = 1'b0;
		forever #37 sub_clk = ~sub_clk;
	end
endmodule
`default_nettype wire

//--- test/sixteen_bit_measure_timer_test.sv
// self-checking bench for the measuring timer block
// assumes the register port and pins of measure_timer; event source model alongside
`timescale 1ns/1ps
`default_nettype none
module sixteen_bit_measure_timer_test import measure_timer_pkg::*;;
	logic ref_clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic [7:0] rd_data;
	logic pin_i, pin_o, pin_oe, sub_clk, pulse, pulse_oe;
	logic want = 1'b1;
	logic [3:0] lag = 4'h0;
	integer seed = 32'h6acc5d17;
	int n_errors = 0;
	int compares = 0;
	logic [7:0] d;
	logic [15:0] v, w;
	int g, k, m, p, q, r;
	// ----------------------------------------
	// design, far side and clock
	// ----------------------------------------
	measure_timer measure_timer_i (.ref_clk(ref_clk), .reset(reset), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .wide_event_pin_i(pin_i),
		.wide_event_pin_o(pin_o), .wide_event_pin_oe(pin_oe), .sub_clock_input(sub_clk),
		.small_pulse_out(pulse), .small_pulse_out_oe(pulse_oe));
	event_source event_source_i (.ref_clk(ref_clk), .want_level(want), .lag(lag), .drv_o(pin_o),
		.drv_oe(pin_oe), .pin(pin_i), .sub_clk(sub_clk));
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	// ----------------------------------------
	// expectations, checks and bus cycles
	// ----------------------------------------
	function automatic logic exp_flag(int mode, int pol, int rise);
		return (mode == 3) || (mode == 1 && rise == pol);
	endfunction
	function automatic int tgap(int n, int div);
		return (n + 1) * div;
	endfunction
	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		compares++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task results;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task wr(input logic [7:0] a, input logic [7:0] x);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= a;
		wr_data <= x;
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] x);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(negedge ref_clk);
		x = rd_data;
	endtask
	// low byte then high byte back to back, high byte loads both
	task wwide(input logic [15:0] x);
		@(posedge ref_clk);
		wr_en <= 1'b1;
		addr <= OFS_WIDE_LO;
		wr_data <= x[7:0];
		@(posedge ref_clk);
		addr <= OFS_WIDE_HI;
		wr_data <= x[15:8];
		@(posedge ref_clk);
		wr_en <= 1'b0;
	endtask
	// high byte then low byte back to back, low byte from the snapshot
	task rwide(output logic [15:0] x);
		@(posedge ref_clk);
		rd_en <= 1'b1;
		addr <= OFS_WIDE_HI;
		@(posedge ref_clk);
		addr <= OFS_WIDE_LO;
		@(negedge ref_clk);
		x[15:8] = rd_data;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		@(negedge ref_clk);
		x[7:0] = rd_data;
	endtask
	// cycles between two toggles of a pin output, bounded
	task gap(input bit sel, output int c);
		logic l;
		for (int i = 0; i < 2; i++) begin
			c = 0;
			l = sel ? pulse : pin_o;
			while ((sel ? pulse : pin_o) === l && c < 3000) begin
				@(negedge ref_clk);
				c++;
			end
		end
		if (c >= 3000) begin
			n_errors++;
			results();
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		cyc(1);
		check(pin_oe, 0, "event oe");
		check(pulse_oe, 0, "pulse oe");
		for (k = 0; k < 4; k++) begin
			rd(k == 0 ? OFS_WIDE_MODE : k == 1 ? OFS_SMALL_MODE : k == 2 ? OFS_STATUS : 8'h30, d);
			check(d, 8'h00, "reset read");
		end
		r = $random(seed);
		wr(OFS_SMALL_MODE, r[7:0]);
		rd(OFS_SMALL_MODE, d);
		check(d, r[7:0], "small mode");
		// stopped count holds; latch-only write leaves counter alone
		wr(OFS_WIDE_MODE, 8'h80);
		v = 16'($random(seed));
		wwide(v);
		cyc(300);
		rwide(w);
		check(w, v, "stopped count");
		wr(OFS_WIDE_MODE, 8'h81);
		wwide(~v);
		rwide(w);
		check(w, v, "latch only");
		// interval mode with toggle output, every prescale
		for (p = 0; p < 4; p++) begin
			q = $random(seed) & 1;
			k = 2 + ($random(seed) & 3);
			m = 8'h82 | (q << 6) | (p << 2);
			wr(OFS_WIDE_MODE, m[7:0]);
			cyc(2);
			check(pin_oe, 1, "event oe on");
			check(pin_o, !q, "toggle start");
			wwide(k[15:0]);
			wr(OFS_WIDE_MODE, m[7:0] & 8'h7F);
			gap(0, g);
			check(g, tgap(k, 8 << p), "toggle gap");
		end
		rd(OFS_STATUS, d);
		check(d[ST_WIDE_UF], 1, "wide underflow");
		wr(OFS_WIDE_MODE, 8'h00);
		cyc(2);
		check(pin_oe, 0, "event oe off");
		// pin edges in each measuring mode, polarity and direction
		for (m = 1; m < 4; m++) for (q = 0; q < 2; q++) for (r = 0; r < 2; r++) begin
			want <= !r;
			lag <= 4'($random(seed)) & 4'h7;
			cyc(30);
			wr(OFS_WIDE_MODE, 8'((m == 2 ? 0 : 8'h80) | (q << 6) | (m << 4)));
			v = 16'h0100 + (16'($random(seed)) & 16'h7FFF);
			wwide(v);
			wr(OFS_STATUS, 8'h0F);
			want <= r[0];
			cyc(40);
			rd(OFS_STATUS, d);
			check(d[ST_PIN_EDGE], exp_flag(m, q, r), "pin flag");
			rwide(w);
			if (m == 2) begin
				check(w, v - 16'(r != q), "event count");
			end else if (exp_flag(m, q, r)) begin
				check(w, v, "capture");
			end
		end
		wr(OFS_WIDE_MODE, 8'h10);
		wwide(16'h0003);
		wr(OFS_STATUS, 8'h0F);
		cyc(100);
		rd(OFS_STATUS, d);
		check(d[ST_WIDE_UF], 1, "measure underflow");
		// small timer: stop bit and latch-only write; wide prescale off /8
		wr(OFS_WIDE_MODE, 8'h0C);
		wr(OFS_SMALL_MODE, 8'h02);
		wr(OFS_SMALL1, 8'd200);
		wr(OFS_SMALL_MODE, 8'h82);
		wr(OFS_SMALL1, 8'd3);
		rd(OFS_SMALL1, d);
		check(d, 8'd200, "small latch only");
		wr(OFS_SMALL_MODE, 8'h02);
		wr(OFS_SMALL1, 8'd3);
		rd(OFS_SMALL1, d);
		check(d, 8'd3, "small direct");
		// pulse output from either small timer
		for (r = 0; r < 2; r++) begin
			q = $random(seed) & 1;
			k = 3 + ($random(seed) & 7);
			m = 8'h42 | (q << 5) | r;
			wr(OFS_SMALL_MODE, m[7:0]);
			cyc(2);
			check(pulse_oe, 1, "pulse oe on");
			check(pulse, !q, "pulse start");
			wr(OFS_SMALL1, k[7:0]);
			wr(OFS_SMALL2, k[7:0]);
			wr(OFS_SMALL_MODE, 8'((m & 8'hFD) | (r << 3)));
			gap(1, g);
			check(g, r ? tgap(k, 1) : tgap(k, 8), "pulse gap");
		end
		wr(OFS_SMALL_MODE, 8'h44);
		wr(OFS_SMALL1, 8'd1);
		gap(1, g);
		check(g > 33 && g < 41, 1, "sub clock gap");
		wr(OFS_SMALL_MODE, 8'h00);
		cyc(2);
		check(pulse_oe, 0, "pulse oe off");
		results();
	end
endmodule
`default_nettype wire
